/* File: hw/blcr_field_reg.sv */
// Purpose : One 32-bit configuration register with masked, byte-enabled writes
// Assumes : Soft clear comes from the same clock domain
// Notes   : Bits outside the mask keep their reset value forever
`timescale 1ns/10ps
module blcr_field_reg
    import blcr_pkg::*;
#(
    parameter logic [31:0] RESET_VAL = 32'h0000_0000,
    parameter logic [31:0] WR_MASK   = 32'hffff_ffff
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_clear,
    input  wire logic        i_wr,
    input  wire logic [3:0]  i_be,
    input  wire logic [31:0] i_wdata,
    output logic      [31:0] o_q
);

    logic [31:0] q_ff;
    logic [31:0] nxt_q;

    // Read-only bits are never touched by a write
    assign nxt_q = i_wr ? blcr_merge(q_ff, i_wdata, i_be, WR_MASK) : q_ff;
    assign o_q   = q_ff;

    // Any reset source returns the register to its default
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || i_clear) begin
            q_ff <= RESET_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end

endmodule

/* File: hw/blcr_pin_sync.sv */
// Purpose : Bring an asynchronous active-low reset pin into the clock domain
// Assumes : Pin is slow compared with the clock
// Notes   : Output moves only when stages two and three agree
`timescale 1ns/10ps
module blcr_pin_sync (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_pin_n,
    output logic      o_level_n
);

    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic level_ff;
    logic nxt_level;

    // Filtered level follows only an agreed value
    assign nxt_level = (sync2_ff == sync3_ff) ? sync3_ff : level_ff;
    assign o_level_n = level_ff;

    // Three-stage chain; starts in the asserted state so fields stay cleared
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            level_ff <= 1'b0;
        end else begin
            sync1_ff <= i_pin_n;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            level_ff <= nxt_level;
        end
    end

endmodule

/* File: hw/blcr_regs.sv */
// Purpose : Link training counts, deep idle saving, window enable and subsystem alias
// Assumes : Configuration accesses and serial-memory loads arrive on i_clock
// Notes   : Read data returns one cycle after the read strobe
`timescale 1ns/10ps

// Function
// - Separate clock: send count from 31:24
// - Shared clock: send count from 23:16
// - Bit 7 enables saving in L2
// - Bit 5 enables the first window
// - Bit 6 always reads zero
// - Three reset sources restore all defaults
// - Alias upper half shows at 46h
// - Alias lower half shows at 44h
// - Alias register at D0h, resets zero
// - General control at D4h, mixed access
module blcr_regs
    import blcr_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_fund_reset_n,
    input  wire logic        i_global_reset_pin_n,
    input  wire logic        i_por_n,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_rd,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [3:0]  i_cfg_be,
    input  wire logic [31:0] i_cfg_wdata,
    input  wire logic        i_load_valid,
    input  wire logic [7:0]  i_load_addr,
    input  wire logic [31:0] i_load_data,
    input  wire logic        i_shared_clock_config_bit,
    input  wire logic        i_l0s_exit,
    input  wire logic        i_fts_slot,
    input  wire logic        i_link_in_l2,
    input  wire logic        i_window_hit,
    output logic      [31:0] o_cfg_rdata,
    output logic             o_cfg_rack,
    output logic             o_load_ack,
    output logic             o_fts_tx,
    output logic             o_fts_busy,
    output logic             o_deep_idle_active,
    output logic             o_first_window_enable,
    output logic             o_window_claim,
    output logic      [15:0] o_board_product_code,
    output logic      [15:0] o_board_maker_code,
    output logic      [4:0]  o_link_number,
    output logic      [31:0] o_general_control
);

    // ************************************************************
    // Reset sources
    // ************************************************************
    logic fund_level_n;
    logic global_reset_pin_level_n;
    logic por_level_n;
    logic field_clear;

    blcr_pin_sync u_sync_fund (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_pin_n   (i_fund_reset_n),
        .o_level_n (fund_level_n)
    );

    blcr_pin_sync u_sync_global_reset_pin (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_pin_n   (i_global_reset_pin_n),
        .o_level_n (global_reset_pin_level_n)
    );

    blcr_pin_sync u_sync_por (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_pin_n   (i_por_n),
        .o_level_n (por_level_n)
    );

    // Any one of the three returns every writable field to default
    assign field_clear = !fund_level_n || !global_reset_pin_level_n || !por_level_n;

    // ************************************************************
    // Write path
    // ************************************************************
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [3:0]  wr_be;
    logic [31:0] wr_data;
    logic        wr_link_train;
    logic        wr_subsys;
    logic        wr_gen_ctrl;

    // Loader owns the port when both strike at once; a config write then is dropped
    assign wr_en   = i_load_valid || i_cfg_wr;
    assign wr_addr = i_load_valid ? i_load_addr : i_cfg_addr;
    assign wr_be   = i_load_valid ? 4'hf : i_cfg_be;
    assign wr_data = i_load_valid ? i_load_data : i_cfg_wdata;

    // Address decode; held off while any reset source is active
    assign wr_link_train = wr_en && !field_clear && (wr_addr == OFF_LINK_TRAIN);
    assign wr_subsys     = wr_en && !field_clear && (wr_addr == OFF_SUBSYS_ALIAS);
    assign wr_gen_ctrl   = wr_en && !field_clear && (wr_addr == OFF_GEN_CTRL);

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [31:0] link_train_q;
    logic [31:0] subsys_q;
    logic [31:0] gen_ctrl_q;

    // Mask keeps the revision field and bit 6 out of reach of writes
    blcr_field_reg #(
        .RESET_VAL (LINK_TRAIN_RESET),
        .WR_MASK   (LINK_TRAIN_WMASK)
    ) u_link_train (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_clear (field_clear),
        .i_wr    (wr_link_train),
        .i_be    (wr_be),
        .i_wdata (wr_data),
        .o_q     (link_train_q)
    );

    blcr_field_reg #(
        .RESET_VAL (SUBSYS_RESET),
        .WR_MASK   (SUBSYS_WMASK)
    ) u_subsys (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_clear (field_clear),
        .i_wr    (wr_subsys),
        .i_be    (wr_be),
        .i_wdata (wr_data),
        .o_q     (subsys_q)
    );

    blcr_field_reg #(
        .RESET_VAL (GEN_CTRL_RESET),
        .WR_MASK   (GEN_CTRL_WMASK)
    ) u_gen_ctrl (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_clear (field_clear),
        .i_wr    (wr_gen_ctrl),
        .i_be    (wr_be),
        .i_wdata (wr_data),
        .o_q     (gen_ctrl_q)
    );

    // ************************************************************
    // Field views
    // ************************************************************
    logic [7:0]  fts_count_separate_clock;
    logic [7:0]  fts_count_shared_clock;
    logic [7:0]  fts_count_sel;
    logic        deep_idle_saving_enable;
    logic        first_window_enable;
    logic [31:0] link_train_view;
    logic [31:0] subsys_ids_view;

    assign fts_count_separate_clock = link_train_q[FTS_SEP_MSB:FTS_SEP_LSB];
    assign fts_count_shared_clock   = link_train_q[FTS_SHR_MSB:FTS_SHR_LSB];
    assign deep_idle_saving_enable  = link_train_q[DEEP_IDLE_BIT];
    assign first_window_enable      = link_train_q[WINDOW_EN_BIT];

    // Shared reference clock needs fewer sequences to relock
    assign fts_count_sel = i_shared_clock_config_bit ? fts_count_shared_clock
                                                     : fts_count_separate_clock;

    // Revision is wired in; bit 6 forced low; bits 4:0 read back as loaded
    always_comb begin
        link_train_view = link_train_q;
        link_train_view[PHY_REVISION_FIELD_MSB:PHY_REVISION_FIELD_LSB] = PHY_REVISION_FIELD_VALUE;
        link_train_view[RSVD_ZERO_BIT] = 1'b0;
    end

    // Identifier dword is a read-only mirror of the alias register
    assign subsys_ids_view = {subsys_q[PRODUCT_MSB:PRODUCT_LSB],
                              subsys_q[MAKER_MSB:MAKER_LSB]};

    // ************************************************************
    // Read path
    // ************************************************************
    logic [31:0] rd_mux;

    // Unmapped offsets read as zero
    always_comb begin
        if (i_cfg_addr == OFF_LINK_TRAIN) begin
            rd_mux = link_train_view;
        end else if (i_cfg_addr == OFF_SUBSYS_ALIAS) begin
            rd_mux = subsys_q;
        end else if (i_cfg_addr == OFF_GEN_CTRL) begin
            rd_mux = gen_ctrl_q;
        end else if (i_cfg_addr == OFF_SUBSYS_IDS) begin
            rd_mux = subsys_ids_view;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    logic [31:0] cfg_rdata_ff;
    logic        cfg_rack_ff;
    logic        load_ack_ff;

    // Read answer and loader acknowledge, one cycle after the strobe
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cfg_rdata_ff <= 32'h0000_0000;
            cfg_rack_ff  <= 1'b0;
            load_ack_ff  <= 1'b0;
        end else begin
            cfg_rdata_ff <= i_cfg_rd ? rd_mux : 32'h0000_0000;
            cfg_rack_ff  <= i_cfg_rd;
            load_ack_ff  <= i_load_valid && !field_clear;
        end
    end

    // ************************************************************
    // Fast training sequence sender
    // ************************************************************
    typedef enum logic [0:0] {FTS_IDLE, FTS_SEND} blcr_fts_state_t;

    blcr_fts_state_t state_ff;
    blcr_fts_state_t nxt_state;
    logic [7:0]      remain_ff;
    logic [7:0]      nxt_remain;
    logic            fts_tx_ff;
    logic            nxt_fts_tx;
    logic            busy_ff;

    // Count is sampled on the exit request; a zero count sends nothing
    always_comb begin
        nxt_state  = state_ff;
        nxt_remain = remain_ff;
        nxt_fts_tx = 1'b0;
        case (state_ff)
            FTS_IDLE: begin
                if (i_l0s_exit && (fts_count_sel != 8'h00)) begin
                    nxt_state  = FTS_SEND;
                    nxt_remain = fts_count_sel;
                end
            end
            FTS_SEND: begin
                if (i_fts_slot) begin
                    nxt_fts_tx = 1'b1;
                    nxt_remain = remain_ff - 8'h01;
                    if (remain_ff == 8'h01) begin
                        nxt_state = FTS_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = FTS_IDLE;
            end
        endcase
    end

    // A reset source aborts any burst in flight
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || field_clear) begin
            state_ff  <= FTS_IDLE;
            remain_ff <= 8'h00;
            fts_tx_ff <= 1'b0;
            busy_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            remain_ff <= nxt_remain;
            fts_tx_ff <= nxt_fts_tx;
            busy_ff   <= (nxt_state == FTS_SEND); // Same timing as the state, but from a flop
        end
    end

    // ************************************************************
    // Power saving, window and identity outputs
    // ************************************************************
    logic        deep_idle_ff;
    logic        window_en_ff;
    logic        window_claim_ff;
    logic [15:0] product_ff;
    logic [15:0] maker_ff;
    logic [4:0]  link_num_ff;
    logic [31:0] gen_ctrl_ff;

    // Registered copies so every output leaves from a flop
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            deep_idle_ff    <= 1'b0;
            window_en_ff    <= 1'b0;
            window_claim_ff <= 1'b0;
            product_ff      <= 16'h0000;
            maker_ff        <= 16'h0000;
            link_num_ff     <= 5'h00;
            gen_ctrl_ff     <= GEN_CTRL_RESET;
        end else begin
            deep_idle_ff    <= deep_idle_saving_enable && i_link_in_l2;
            window_en_ff    <= first_window_enable;
            window_claim_ff <= first_window_enable && i_window_hit;
            product_ff      <= subsys_q[PRODUCT_MSB:PRODUCT_LSB];
            maker_ff        <= subsys_q[MAKER_MSB:MAKER_LSB];
            link_num_ff     <= link_train_q[LINK_NUM_MSB:LINK_NUM_LSB];
            gen_ctrl_ff     <= gen_ctrl_q;
        end
    end

    assign o_cfg_rdata           = cfg_rdata_ff;
    assign o_cfg_rack            = cfg_rack_ff;
    assign o_load_ack            = load_ack_ff;
    assign o_fts_tx              = fts_tx_ff;
    assign o_fts_busy            = busy_ff;
    assign o_deep_idle_active    = deep_idle_ff;
    assign o_first_window_enable = window_en_ff;
    assign o_window_claim        = window_claim_ff;
    assign o_board_product_code  = product_ff;
    assign o_board_maker_code    = maker_ff;
    assign o_link_number         = link_num_ff;
    assign o_general_control     = gen_ctrl_ff;

endmodule

/* File: shared/blcr_pkg.sv */
// Purpose : Constants for the bridge link and subsystem configuration register bank
// Assumes : Byte offsets into configuration space, 32-bit aligned registers
// Notes   : Masks mark the bits that a write may change
package blcr_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0]  OFF_LINK_TRAIN    = 8'hc8;
    localparam logic [7:0]  OFF_SUBSYS_ALIAS  = 8'hd0;
    localparam logic [7:0]  OFF_GEN_CTRL      = 8'hd4;
    localparam logic [7:0]  OFF_SUBSYS_IDS    = 8'h44;

    // ************************************************************
    // Link training and window control fields
    // ************************************************************
    localparam int          FTS_SEP_MSB       = 31;
    localparam int          FTS_SEP_LSB       = 24;
    localparam int          FTS_SHR_MSB       = 23;
    localparam int          FTS_SHR_LSB       = 16;
    localparam int          PHY_REVISION_FIELD_MSB       = 15;
    localparam int          PHY_REVISION_FIELD_LSB       = 13;
    localparam int          LINK_NUM_MSB      = 12;
    localparam int          LINK_NUM_LSB      = 8;
    localparam int          DEEP_IDLE_BIT     = 7;
    localparam int          RSVD_ZERO_BIT     = 6;
    localparam int          WINDOW_EN_BIT     = 5;
    localparam logic [2:0]  PHY_REVISION_FIELD_VALUE     = 3'h1;
    localparam logic [31:0] LINK_TRAIN_RESET  = 32'h3214_0000;
    localparam logic [31:0] LINK_TRAIN_WMASK  = 32'hffff_1fbf;

    // ************************************************************
    // Subsystem alias fields
    // ************************************************************
    localparam int          PRODUCT_MSB       = 31;
    localparam int          PRODUCT_LSB       = 16;
    localparam int          MAKER_MSB         = 15;
    localparam int          MAKER_LSB         = 0;
    localparam logic [31:0] SUBSYS_RESET      = 32'h0000_0000;
    localparam logic [31:0] SUBSYS_WMASK      = 32'hffff_ffff;

    // ************************************************************
    // General control register
    // ************************************************************
    localparam logic [31:0] GEN_CTRL_RESET    = 32'h8600_025f;
    localparam logic [31:0] GEN_CTRL_WMASK    = 32'hfeff_ffff;

    // Merge a write into a register under byte enables and a write mask
    function automatic logic [31:0] blcr_merge(input logic [31:0] old_val,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  be,
                                               input logic [31:0] wmask);
        logic [31:0] lane;
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        return (old_val & ~lane) | (wdata & lane);
    endfunction

endpackage

/* File: testbench/blcr_regs_checker.sv */
// Purpose : Port-level assertions for the link and subsystem register bank
// Assumes : Single clock domain, synchronous active-low reset
// Notes   : Sees only top-level ports; internal fields inferred from reads
`timescale 1ns/10ps
module blcr_regs_checker
    import blcr_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic        i_fund_reset_n,
    input wire logic        i_global_reset_pin_n,
    input wire logic        i_por_n,
    input wire logic        i_cfg_rd,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic        i_load_valid,
    input wire logic        i_l0s_exit,
    input wire logic        i_fts_slot,
    input wire logic        i_link_in_l2,
    input wire logic        i_window_hit,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic        o_cfg_rack,
    input wire logic        o_load_ack,
    input wire logic        o_fts_tx,
    input wire logic        o_fts_busy,
    input wire logic        o_deep_idle_active,
    input wire logic        o_first_window_enable,
    input wire logic        o_window_claim,
    input wire logic [15:0] o_board_product_code,
    input wire logic [15:0] o_board_maker_code,
    input wire logic [31:0] o_general_control
);
    // ************************************************************
    // Sequences and assertions
    // ************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // Reads of the training register and of the identity mirror
    sequence s_train_read;
        (i_cfg_rd && i_cfg_addr == OFF_LINK_TRAIN) ##1 o_cfg_rack;
    endsequence
    sequence s_mirror_read;
        (i_cfg_rd && i_cfg_addr == OFF_SUBSYS_IDS) ##1 o_cfg_rack;
    endsequence
    // Six cycles low covers the three-flop synchroniser on any pin
    sequence s_pin_low;
        (!i_fund_reset_n || !i_global_reset_pin_n || !i_por_n) [*6];
    endsequence

    a_read_answer: assert property (i_cfg_rd |=> o_cfg_rack)
        else $error("read strobe not answered next cycle");
    a_no_stray_rack: assert property (!i_cfg_rd |=> !o_cfg_rack && o_cfg_rdata == 32'h0)
        else $error("read answer without strobe");
    a_fixed_bits: assert property (s_train_read |->
        o_cfg_rdata[RSVD_ZERO_BIT] == 1'b0 &&
        o_cfg_rdata[PHY_REVISION_FIELD_MSB:PHY_REVISION_FIELD_LSB] == PHY_REVISION_FIELD_VALUE)
        else $error("read-only training bits wrong");
    a_id_mirror: assert property (s_mirror_read |->
        o_cfg_rdata == {o_board_product_code, o_board_maker_code})
        else $error("identity mirror differs from outputs");
    a_pin_defaults: assert property (s_pin_low |-> ##[0:3]
        (o_general_control == GEN_CTRL_RESET && !o_first_window_enable))
        else $error("reset pin did not restore defaults");
    a_idle_needs_l2: assert property (o_deep_idle_active |-> $past(i_link_in_l2))
        else $error("deep idle saving outside L2");
    a_claim_enabled: assert property (o_window_claim |->
        o_first_window_enable && $past(i_window_hit))
        else $error("window claimed while disabled");
    a_fts_slot: assert property (o_fts_tx |->
        $past(i_fts_slot) && $past(o_fts_busy))
        else $error("training sequence sent without slot");
    a_fts_start: assert property ($rose(o_fts_busy) |-> $past(i_l0s_exit))
        else $error("burst started without request");
    a_load_ack: assert property (o_load_ack |-> $past(i_load_valid))
        else $error("loader ack without load");
endmodule

/* File: testbench/test_blcr_regs.sv */
// Purpose : Self-checking bench for the link and subsystem register bank
// Assumes : Config strobes are one-cycle pulses driven 1 ns after the edge
// Notes   : Read answers are checked one cycle after the strobe
`timescale 1ns/10ps
module test_blcr_regs
    import blcr_pkg::*;
;
    logic        i_clock, i_rst_n, i_cfg_wr, i_cfg_rd, i_load_valid;
    logic        i_shared_clock_config_bit, i_l0s_exit, i_fts_slot;
    logic        i_link_in_l2, i_window_hit;
    logic [2:0]  pins_n;
    logic [7:0]  i_cfg_addr, i_load_addr;
    logic [3:0]  i_cfg_be;
    logic [31:0] i_cfg_wdata, i_load_data, o_cfg_rdata, o_general_control;
    logic        o_cfg_rack, o_load_ack, o_fts_tx, o_fts_busy;
    logic        o_deep_idle_active, o_first_window_enable, o_window_claim;
    logic [15:0] o_board_product_code, o_board_maker_code;
    logic [4:0]  o_link_number;
    int          miscompares, checks, k;

    blcr_regs blcr_regs_inst (.i_clock, .i_rst_n, .i_fund_reset_n(pins_n[0]),
        .i_global_reset_pin_n(pins_n[1]), .i_por_n(pins_n[2]), .i_cfg_wr, .i_cfg_rd,
        .i_cfg_addr, .i_cfg_be, .i_cfg_wdata, .i_load_valid, .i_load_addr, .i_load_data,
        .i_shared_clock_config_bit, .i_l0s_exit, .i_fts_slot, .i_link_in_l2,
        .i_window_hit, .o_cfg_rdata, .o_cfg_rack, .o_load_ack, .o_fts_tx, .o_fts_busy,
        .o_deep_idle_active, .o_first_window_enable, .o_window_claim,
        .o_board_product_code, .o_board_maker_code, .o_link_number, .o_general_control);

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge i_clock); #1;
        i_cfg_wr = 1'b1; i_cfg_addr = a; i_cfg_be = be; i_cfg_wdata = d;
        @(posedge i_clock); #1;
        i_cfg_wr = 1'b0;
    endtask

    // Answer registers one edge after the strobe, so sample just after it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clock); #1;
        i_cfg_rd = 1'b1; i_cfg_addr = a;
        @(posedge i_clock); #1;
        i_cfg_rd = 1'b0;
        chk({31'h0, o_cfg_rack}, 32'h1);
        chk(o_cfg_rdata, e);
    endtask

    // Slot toggles every cycle so the burst must wait for each opening
    task automatic fts(input int exp);
        int n;
        n = 0;
        @(posedge i_clock); #1 i_l0s_exit = 1'b1;
        @(posedge i_clock); #1 i_l0s_exit = 1'b0;
        chk({31'h0, o_fts_busy}, 32'h1);
        repeat (40) begin
            @(posedge i_clock); #1 i_fts_slot = ~i_fts_slot;
            if (o_fts_tx === 1'b1) n++;
        end
        chk(n, exp);
        chk({31'h0, o_fts_busy}, 32'h0);
    endtask

    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    // Watchdog: the whole sequence needs well under ten thousand cycles
    initial begin
        #100000;
        miscompares++;
        final_report();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        {i_rst_n, i_cfg_wr, i_cfg_rd, i_load_valid, i_l0s_exit, i_fts_slot} = 6'h0;
        {i_shared_clock_config_bit, i_link_in_l2, i_window_hit} = 3'h0;
        pins_n = 3'h7; i_cfg_addr = 8'h0; i_cfg_be = 4'h0; i_cfg_wdata = 32'h0;
        i_load_addr = 8'h0; i_load_data = 32'h0; miscompares = 0; checks = 0;
        repeat (5) @(posedge i_clock);
        #1 i_rst_n = 1'b1;
        repeat (6) @(posedge i_clock);
        rd(OFF_LINK_TRAIN, 32'h3214_2000);
        rd(OFF_SUBSYS_ALIAS, 32'h0000_0000);
        rd(OFF_GEN_CTRL, 32'h8600_025f);
        rd(8'hc0, 32'h0000_0000);
        $display("test reset_values done");

        wr(OFF_LINK_TRAIN, 4'hf, 32'hffff_ffe0);
        rd(OFF_LINK_TRAIN, 32'hffff_3fa0);
        wr(OFF_LINK_TRAIN, 4'h8, 32'h0500_0000);
        rd(OFF_LINK_TRAIN, 32'h05ff_3fa0);
        chk({27'h0, o_link_number}, 32'h0000_001f);
        i_link_in_l2 = 1'b1; i_window_hit = 1'b1;
        repeat (2) @(posedge i_clock); #1;
        chk({29'h0, o_deep_idle_active, o_first_window_enable, o_window_claim},
            32'h0000_0007);
        fts(5);
        wr(OFF_LINK_TRAIN, 4'h5, 32'h0003_0000);
        repeat (2) @(posedge i_clock); #1;
        chk({29'h0, o_deep_idle_active, o_first_window_enable, o_window_claim},
            32'h0000_0000);
        i_shared_clock_config_bit = 1'b1;
        fts(3);
        $display("test link_training done");

        wr(OFF_SUBSYS_ALIAS, 4'hf, 32'h1234_5678);
        rd(OFF_SUBSYS_ALIAS, 32'h1234_5678);
        rd(OFF_SUBSYS_IDS, 32'h1234_5678);
        chk({o_board_product_code, o_board_maker_code}, 32'h1234_5678);
        wr(OFF_GEN_CTRL, 4'hf, 32'hffff_ffff);
        rd(OFF_GEN_CTRL, 32'hfeff_ffff);
        chk(o_general_control, 32'hfeff_ffff);
        // Loader and a config write collide; the loader must win
        @(posedge i_clock); #1;
        i_load_valid = 1'b1; i_load_addr = OFF_SUBSYS_ALIAS; i_load_data = 32'habcd_ef01;
        i_cfg_wr = 1'b1; i_cfg_addr = OFF_SUBSYS_ALIAS; i_cfg_be = 4'hf;
        @(posedge i_clock); #1;
        i_load_valid = 1'b0; i_cfg_wr = 1'b0;
        chk({31'h0, o_load_ack}, 32'h1);
        rd(OFF_SUBSYS_ALIAS, 32'habcd_ef01);
        $display("test alias_and_loader done");

        // Each reset source in turn must restore every writable field
        for (k = 0; k < 3; k++) begin
            wr(OFF_SUBSYS_ALIAS, 4'hf, 32'h5a5a_0f0f);
            wr(OFF_LINK_TRAIN, 4'hf, 32'h0000_00a0);
            wr(OFF_GEN_CTRL, 4'hf, 32'h0000_0000);
            pins_n[k] = 1'b0;
            repeat (6) @(posedge i_clock); #1;
            pins_n[k] = 1'b1;
            repeat (6) @(posedge i_clock);
            rd(OFF_SUBSYS_ALIAS, 32'h0000_0000);
            rd(OFF_LINK_TRAIN, 32'h3214_2000);
            rd(OFF_GEN_CTRL, 32'h8600_025f);
        end
        $display("test reset_sources done");
        final_report();
    end
endmodule

bind blcr_regs blcr_regs_checker blcr_regs_checker_inst (.i_clock, .i_rst_n,
    .i_fund_reset_n, .i_global_reset_pin_n, .i_por_n, .i_cfg_rd, .i_cfg_addr,
    .i_load_valid, .i_l0s_exit, .i_fts_slot, .i_link_in_l2, .i_window_hit, .o_cfg_rdata,
    .o_cfg_rack, .o_load_ack, .o_fts_tx, .o_fts_busy, .o_deep_idle_active,
    .o_first_window_enable, .o_window_claim, .o_board_product_code, .o_board_maker_code,
    .o_general_control);
